// [dcadc_pkg.sv]
// Constants, types and state names for the two-channel converter readout.
// Assumes a single 40 MHz clock and synchronous active-high reset.
// Behaviour
// - 19-bit frame: busy, channel, sign, 16 bits
// - Zero gives sign 1, rest zero
// - Clamp beyond full scale to fixed codes
// - Toggling conversion clock pin disables oscillator
// - No external clock selects internal oscillator
// - Clock source change harms one result at most
// - Source change keeps internal bit stream valid
// - Internal serial clock is conversion clock over 8
// - Data changes on serial clock falling edges
// - Clock pin level at select fall sets mode
// - Data pin released while chip select high
// - Busy flag shown while converting, low while sleeping
// - Output state shifts latest result, MSB first
// - Chip select rise after first edge aborts
// - Select held low converts continuously
// - Internal oscillator conversion lasts 147 ms
// - Internal output ends after 19 clocks
// - Nineteenth external falling edge starts conversion
// - Reset clears state and selects channel zero
package dcadc_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int FRAME_BITS = 19;
    localparam int WORD_BITS = 18;
    localparam logic [14:0] CONV_TICKS = 15'h501e;
    localparam longint CONV_INT_NS = 147_000_000;
    localparam longint TICK_SPAN_NS = longint'(CONV_TICKS) * CLK_PERIOD_NS;
    // Internal oscillator period, rounded up so a conversion is never short
    localparam logic [8:0] INT_TICK_CYC = 9'((CONV_INT_NS + TICK_SPAN_NS - 1) / TICK_SPAN_NS);
    localparam int DETECT_MIN_HZ = 2560;
    // Two periods of the slowest detectable clock
    localparam int DETECT_WIN_CYC = 2 * CLK_HZ / DETECT_MIN_HZ;
    localparam logic [1:0] SCK_HALF_TICKS = 2'h3;
    localparam logic [4:0] LAST_BIT = 5'h13;
    localparam logic [16:0] CODE_ZERO = 17'h10000;
    localparam logic [16:0] CODE_POS_CLAMP = 17'h18000;
    localparam logic [16:0] CODE_NEG_CLAMP = 17'h07fff;
    localparam logic signed [17:0] VIN_MAX = 18'sh07fff;
    localparam logic signed [17:0] VIN_MIN = 18'sh38000;
    localparam logic CHAN_RST = 1'b0;
    typedef enum logic [1:0] {ST_CONVERT, ST_SLEEP, ST_OUTPUT} dcadc_state_t;
endpackage : dcadc_pkg

// [dcadc_word_if.sv]
// Valid/ready carrier for one result word between converter and shifter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dcadc_word_if import dcadc_pkg::*; ();
    logic valid;
    logic ready;
    logic [WORD_BITS-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dcadc_word_if

// [dcadc_buf2.sv]
// Two-entry result buffer with valid and ready on both sides.
// Assumes the filling side holds data while valid and not ready.
`timescale 1ns/1ps
module dcadc_buf2 import dcadc_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    dcadc_word_if.snk in_if,
    dcadc_word_if.src out_if
);
    logic [WORD_BITS-1:0] mem_r [2];
    logic wr_r;
    logic rd_r;
    logic [1:0] cnt_r;

    wire push = in_if.valid & in_if.ready;
    wire pop = out_if.valid & out_if.ready;

    assign in_if.ready = (cnt_r != 2'h2);
    assign out_if.valid = (cnt_r != 2'h0);
    assign out_if.data = mem_r[rd_r];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_r] <= in_if.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wr_r <= wr_r ^ push;
            rd_r <= rd_r ^ pop;
            cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule : dcadc_buf2

// [dcadc_cclk.sv]
// Conversion clock source: external clock detection and internal oscillator.
// Assumes the select pin is asynchronous to mclk.
`timescale 1ns/1ps
module dcadc_cclk import dcadc_pkg::*; #(
    parameter int DETECT_CYC = DETECT_WIN_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic f0_pin,
    output logic tick,
    output logic ext_present
);
    logic f0_m_r, f0_s_r, f0_d_r;
    logic [15:0] wd_r;
    logic ext_r;
    logic [8:0] osc_r;

    wire f0_rise = f0_s_r & ~f0_d_r;
    wire wd_expired = (wd_r == 16'(DETECT_CYC - 1));
    wire osc_wrap = (osc_r == INT_TICK_CYC - 9'h001);

    assign tick = ext_r ? f0_rise : osc_wrap;
    assign ext_present = ext_r;

    always_ff @(posedge mclk) begin
        f0_m_r <= f0_pin;
        f0_s_r <= f0_m_r;
        f0_d_r <= f0_s_r;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wd_r <= 16'(DETECT_CYC - 1);
            ext_r <= 1'b0;
            osc_r <= 9'h000;
        end else begin
            wd_r <= f0_rise ? 16'h0000 : (wd_expired ? wd_r : wd_r + 16'h0001);
            ext_r <= (f0_rise & ~wd_expired) | (ext_r & ~wd_expired);
            // Oscillator parked while the external clock runs
            osc_r <= (ext_r | osc_wrap) ? 9'h000 : osc_r + 9'h001;
        end
    end

    property p_ext_detect;
        @(posedge mclk) disable iff (rst) (f0_rise && !wd_expired) |=> ext_r;
    endproperty
    a_ext_detect: assert property (p_ext_detect) else $error("external clock missed");

    property p_ext_drop;
        @(posedge mclk) disable iff (rst)
            (wd_expired && !f0_rise) |=> !ext_r && (tick == osc_wrap);
    endproperty
    a_ext_drop: assert property (p_ext_drop) else $error("oscillator not restored");
endmodule : dcadc_cclk

// [dcadc_top.sv]
// Converter state machine and serial result readout for two channels.
// Assumes pins are asynchronous; channel codes come from mclk-domain logic.
`timescale 1ns/1ps
module dcadc_top import dcadc_pkg::*; #(
    parameter int DETECT_CYC = DETECT_WIN_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n_pin,
    input wire logic sck_in,
    input wire logic conversion_clock_select_pin,
    input wire logic signed [17:0] ch0_code,
    input wire logic signed [17:0] ch1_code,
    output logic sck_out,
    output logic sck_oe_n,
    output logic sdo_out,
    output logic sdo_oe_n,
    output logic conv_busy,
    output logic int_osc_on
);
    dcadc_state_t state_r, state_nxt;
    logic [14:0] conv_cnt_r, conv_cnt_nxt;
    logic chan_r, chan_nxt;
    logic ext_mode_r, ext_mode_nxt;
    logic init_r;
    logic cs_m_r, cs_s_r, cs_d_r;
    logic sck_m_r, sck_s_r, sck_d_r;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [1:0] div_r, div_nxt;
    logic sck_gen_r, sck_gen_nxt;
    logic sdo_r, sdo_oe_n_r, sck_oe_n_r, busy_r, osc_on_r;
    logic tick, ext_present;

    dcadc_word_if conv_if ();
    dcadc_word_if rd_if ();

    dcadc_cclk #(.DETECT_CYC(DETECT_CYC)) u_cclk (
        .mclk(mclk),
        .rst(rst),
        .f0_pin(conversion_clock_select_pin),
        .tick(tick),
        .ext_present(ext_present)
    );

    dcadc_buf2 u_buf (
        .mclk(mclk),
        .rst(rst),
        .in_if(conv_if.snk),
        .out_if(rd_if.src)
    );

    // Pin edge decode
    wire cs_low = ~cs_s_r;
    wire cs_fall = cs_d_r & ~cs_s_r;
    wire cs_rise = ~cs_d_r & cs_s_r;
    wire ext_rise = sck_s_r & ~sck_d_r;
    wire ext_fall = ~sck_s_r & sck_d_r;
    wire int_edge = tick & (div_r == SCK_HALF_TICKS);
    wire int_rise = int_edge & ~sck_gen_r;
    wire int_fall = int_edge & sck_gen_r;
    wire sck_rise = ext_mode_r ? ext_rise : int_rise;
    wire sck_fall = ext_mode_r ? ext_fall : int_fall;

    wire conv_last = tick & (conv_cnt_r == CONV_TICKS - 15'h0001);
    wire conv_done = (state_r == ST_CONVERT) & conv_last & conv_if.ready;

    wire signed [17:0] vin = chan_r ? ch1_code : ch0_code;
    wire over = (vin > VIN_MAX);
    wire under = (vin < VIN_MIN);
    wire [16:0] res_code = over ? CODE_POS_CLAMP :
                           (under ? CODE_NEG_CLAMP : 17'(vin[16:0] + CODE_ZERO));

    wire out_start = (state_r == ST_SLEEP) & cs_low & ~cs_fall & rd_if.valid &
                     (ext_mode_r ? ext_rise : 1'b1);
    wire last_int = ~ext_mode_r & sck_rise & (bit_cnt_r == LAST_BIT - 5'h01);
    wire last_ext = ext_mode_r & sck_fall & (bit_cnt_r == LAST_BIT);
    wire abort = cs_rise & (bit_cnt_r != 5'h00);
    wire out_end = (state_r == ST_OUTPUT) & (abort | last_int | last_ext);
    wire shift_next_bit = shift_r[FRAME_BITS-2];

    assign conv_if.valid = (state_r == ST_CONVERT) & conv_last;
    assign conv_if.data = {chan_r, res_code};
    assign rd_if.ready = out_end;

    wire sdo_nxt = (state_nxt == ST_OUTPUT) ? shift_nxt[FRAME_BITS-1] :
                   (state_nxt == ST_CONVERT);
    wire sck_oe_n_nxt = ext_mode_nxt | cs_s_r;

    always_comb begin
        state_nxt = state_r;
        conv_cnt_nxt = conv_cnt_r;
        chan_nxt = chan_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        div_nxt = div_r;
        sck_gen_nxt = sck_gen_r;
        ext_mode_nxt = ext_mode_r;
        if (init_r | cs_fall) begin
            ext_mode_nxt = ~sck_s_r;
        end
        if (cs_fall & ~ext_mode_nxt) begin
            sck_gen_nxt = 1'b0;
        end
        unique case (state_r)
            ST_CONVERT: begin
                if (tick & ~conv_last) begin
                    conv_cnt_nxt = conv_cnt_r + 15'h0001;
                end
                if (conv_done) begin
                    state_nxt = ST_SLEEP;
                    conv_cnt_nxt = 15'h0000;
                    chan_nxt = ~chan_r;
                end
            end
            ST_SLEEP: begin
                if (out_start) begin
                    state_nxt = ST_OUTPUT;
                    shift_nxt = {1'b0, rd_if.data};
                    div_nxt = 2'h0;
                    sck_gen_nxt = 1'b0;
                    bit_cnt_nxt = ext_mode_r ? 5'h01 : 5'h00;
                end
            end
            ST_OUTPUT: begin
                if (tick & ~ext_mode_r) begin
                    div_nxt = div_r + 2'h1;
                end
                if (int_edge & ~ext_mode_r) begin
                    sck_gen_nxt = ~sck_gen_r;
                end
                if (sck_rise) begin
                    bit_cnt_nxt = bit_cnt_r + 5'h01;
                end
                if (sck_fall) begin
                    shift_nxt = {shift_r[FRAME_BITS-2:0], 1'b0};
                end
                if (out_end) begin
                    state_nxt = ST_CONVERT;
                    bit_cnt_nxt = 5'h00;
                    sck_gen_nxt = 1'b1;
                end else if (cs_rise) begin
                    // Before the first edge the result is kept for a later read
                    state_nxt = ST_SLEEP;
                    bit_cnt_nxt = 5'h00;
                    sck_gen_nxt = 1'b1;
                end
            end
        endcase
    end

    // Pin synchronisers; reset is held long enough to flush them
    always_ff @(posedge mclk) begin
        cs_m_r <= cs_n_pin;
        cs_s_r <= cs_m_r;
        cs_d_r <= cs_s_r;
        sck_m_r <= sck_in;
        sck_s_r <= sck_m_r;
        sck_d_r <= sck_s_r;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_CONVERT;
            conv_cnt_r <= 15'h0000;
            chan_r <= CHAN_RST;
            ext_mode_r <= 1'b0;
            init_r <= 1'b1;
            shift_r <= '0;
            bit_cnt_r <= 5'h00;
            div_r <= 2'h0;
            sck_gen_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            chan_r <= chan_nxt;
            ext_mode_r <= ext_mode_nxt;
            init_r <= 1'b0;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            div_r <= div_nxt;
            sck_gen_r <= sck_gen_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sdo_r <= 1'b1;
            sdo_oe_n_r <= 1'b1;
            sck_oe_n_r <= 1'b1;
            busy_r <= 1'b1;
            osc_on_r <= 1'b1;
        end else begin
            sdo_r <= sdo_nxt;
            sdo_oe_n_r <= cs_s_r;
            sck_oe_n_r <= sck_oe_n_nxt;
            busy_r <= (state_nxt == ST_CONVERT);
            osc_on_r <= ~ext_present;
        end
    end

    assign sdo_out = sdo_r;
    assign sdo_oe_n = sdo_oe_n_r;
    assign sck_out = sck_gen_r;
    assign sck_oe_n = sck_oe_n_r;
    assign conv_busy = busy_r;
    assign int_osc_on = osc_on_r;

    property p_frame_load;
        @(posedge mclk) disable iff (rst)
            (state_r == ST_SLEEP && state_nxt == ST_OUTPUT) |=>
            shift_r == {1'b0, $past(rd_if.data)} && !sdo_out;
    endproperty
    a_frame_load: assert property (p_frame_load) else $error("frame not loaded");

    property p_zero_code;
        @(posedge mclk) disable iff (rst) (vin == 18'sh00000) |-> res_code == CODE_ZERO;
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("zero input miscoded");

    property p_minus_one;
        @(posedge mclk) disable iff (rst) (vin == 18'sh3ffff) |-> res_code == 17'h0ffff;
    endproperty
    a_minus_one: assert property (p_minus_one) else $error("minus one miscoded");

    property p_clamp;
        @(posedge mclk) disable iff (rst)
            (over |-> res_code == 17'h18000) and (under |-> res_code == 17'h07fff);
    endproperty
    a_clamp: assert property (p_clamp) else $error("out of range not clamped");

    property p_sck_div;
        @(posedge mclk) disable iff (rst)
            (state_r == ST_OUTPUT && !ext_mode_r && int_edge && !out_end && !cs_rise)
            |=> sck_out != $past(sck_out);
    endproperty
    a_sck_div: assert property (p_sck_div) else $error("internal clock missed toggle");

    property p_fall_shift;
        @(posedge mclk) disable iff (rst)
            (state_r == ST_OUTPUT && sck_fall && !out_end && !cs_rise)
            |=> sdo_out == $past(shift_next_bit);
    endproperty
    a_fall_shift: assert property (p_fall_shift) else $error("data not shifted");

    property p_mode_sel;
        @(posedge mclk) disable iff (rst) cs_fall |=> ext_mode_r == !$past(sck_s_r);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("clock mode not sampled");

    property p_hiz;
        @(posedge mclk) disable iff (rst) cs_s_r ##1 cs_s_r |-> sdo_oe_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("data pin driven while deselected");

    property p_busy;
        @(posedge mclk) disable iff (rst)
            (state_r == ST_CONVERT && !conv_done && !cs_s_r) |=> sdo_out && !sdo_oe_n;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag not shown");

    property p_eoc_low;
        @(posedge mclk) disable iff (rst) (conv_done && !cs_s_r) |=> !sdo_out && !conv_busy;
    endproperty
    a_eoc_low: assert property (p_eoc_low) else $error("busy flag stuck");

    property p_abort;
        @(posedge mclk) disable iff (rst) (state_r == ST_OUTPUT && abort) |=> state_r == ST_CONVERT;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not restart");

    property p_conv_len;
        @(posedge mclk) disable iff (rst) state_r == ST_CONVERT |-> conv_cnt_r < 15'h501e;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion overran");

    property p_out_len;
        @(posedge mclk) disable iff (rst) state_r == ST_OUTPUT |-> bit_cnt_r <= 5'h13;
    endproperty
    a_out_len: assert property (p_out_len) else $error("readout overran");

    property p_ext_end;
        @(posedge mclk) disable iff (rst)
            (state_r == ST_OUTPUT && last_ext) |=> state_r == ST_CONVERT && sdo_out;
    endproperty
    a_ext_end: assert property (p_ext_end) else $error("no restart on last fall");

    property p_chan;
        @(posedge mclk) disable iff (rst) conv_done |=> chan_r != $past(chan_r);
    endproperty
    a_chan: assert property (p_chan) else $error("channel did not alternate");
endmodule : dcadc_top

// [dcadc_host.sv]
// Host model: serial master that reads result frames from the converter.
// Assumes the bench resolves the clock and data wires and calls its tasks.
`timescale 1ns/1ps
module dcadc_host (
    input wire logic mclk,
    input wire logic sck_pin,
    input wire logic sdo_pin,
    output logic cs_n,
    output logic sck_drv,
    output logic sck_en,
    output logic [18:0] frame_q,
    output logic frame_stb
);
    logic timed_out = 1'b0;

    initial begin
        cs_n = 1'b1;
        sck_drv = 1'b0;
        sck_en = 1'b1;
        frame_q = '0;
        frame_stb = 1'b0;
    end

    task automatic post(input logic [18:0] frame);
        frame_q = frame;
        frame_stb = 1'b1;
        @(negedge mclk);
        frame_stb = 1'b0;
    endtask : post

    task automatic deselect();
        @(negedge mclk);
        cs_n = 1'b1;
    endtask : deselect

    task automatic read_ext(output logic busy_seen);
        logic [18:0] frame;
        int n;
        frame = '0;
        @(negedge mclk);
        sck_en = 1'b1;
        sck_drv = 1'b0;
        @(negedge mclk);
        cs_n = 1'b0;
        repeat (8) @(negedge mclk);
        busy_seen = sdo_pin;
        n = 0;
        while (sdo_pin !== 1'b0 && n < 60000) begin
            @(negedge mclk);
            n++;
        end
        timed_out = timed_out | (n >= 60000);
        for (int i = 18; i >= 0; i--) begin
            // Sampled just as the clock rises
            frame[i] = sdo_pin;
            sck_drv = 1'b1;
            repeat (6) @(negedge mclk);
            sck_drv = 1'b0;
            repeat (6) @(negedge mclk);
        end
        post(frame);
    endtask : read_ext

    task automatic read_int(output int spacing);
        logic [18:0] frame;
        logic prev;
        logic prev_d;
        int n;
        int k;
        int last;
        frame = '0;
        spacing = 0;
        @(negedge mclk);
        sck_en = 1'b0;
        repeat (2) @(negedge mclk);
        cs_n = 1'b0;
        prev = sck_pin;
        prev_d = sdo_pin;
        n = 0;
        k = 0;
        last = 0;
        while (k < 19 && n < 20000) begin
            @(negedge mclk);
            n++;
            // Data as it stood just before the rise; the device may move it with the rise
            if (sck_pin === 1'b1 && prev === 1'b0) begin
                frame[18 - k] = prev_d;
                spacing = n - last;
                last = n;
                k++;
            end
            prev = sck_pin;
            prev_d = sdo_pin;
        end
        timed_out = timed_out | (k < 19);
        post(frame);
    endtask : read_int
endmodule : dcadc_host

// [dcadc_top_tb.sv]
// Self-checking bench for the two-channel converter readout.
// Assumes the host model and a shortened clock detect window.
`timescale 1ns/1ps
module dcadc_top_tb;
    localparam int DET = 64;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic f0 = 1'b0;
    logic f0_run = 1'b0;
    logic sdo_last = 1'b0;
    logic busy_prev = 1'b0;
    logic signed [17:0] ch0_code = '0;
    logic signed [17:0] ch1_code = '0;
    logic cs_n, sck_drv, sck_en, frame_stb, sck_pin, sdo_pin, busy_seen;
    logic sck_out, sck_oe_n, sdo_out, sdo_oe_n, conv_busy, int_osc_on;
    logic [18:0] frame_q;
    logic [18:0] exp_q[$];
    int spacing;
    int busy_ticks = 0;
    int busy_len = 0;
    int err_total = 0;
    int checked = 0;

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    assign sck_pin = (sck_oe_n === 1'b0) ? sck_out : (sck_en ? sck_drv : 1'b1);
    // Undriven data line shows the inverse so stale bits never match
    assign sdo_pin = (sdo_oe_n === 1'b0) ? sdo_out : ~sdo_last;

    dcadc_top #(.DETECT_CYC(DET)) dcadc_top_inst (
        .mclk(mclk), .rst(rst), .cs_n_pin(cs_n), .sck_in(sck_pin),
        .conversion_clock_select_pin(f0), .ch0_code(ch0_code), .ch1_code(ch1_code),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .conv_busy(conv_busy), .int_osc_on(int_osc_on)
    );

    dcadc_host dcadc_host_inst (
        .mclk(mclk), .sck_pin(sck_pin), .sdo_pin(sdo_pin), .cs_n(cs_n),
        .sck_drv(sck_drv), .sck_en(sck_en), .frame_q(frame_q), .frame_stb(frame_stb)
    );

    always @(posedge mclk) begin
        if (sdo_oe_n === 1'b0) begin
            sdo_last <= sdo_out;
        end
    end

    // Fastest conversion clock keeps each conversion near 41k cycles
    always @(negedge mclk) begin
        if (f0_run) begin
            f0 <= ~f0;
        end
        busy_prev <= conv_busy;
        if (conv_busy === 1'b1 && busy_prev !== 1'b1) begin
            busy_ticks <= 0;
        end else if (conv_busy === 1'b1 && f0_run && !f0) begin
            busy_ticks <= busy_ticks + 1;
        end
        if (conv_busy === 1'b0 && busy_prev === 1'b1) begin
            busy_len <= busy_ticks;
        end
    end

    function automatic logic [16:0] exp_code(input logic signed [17:0] v);
        if (v > 18'sh07fff) return 17'h18000;
        if (v < 18'sh38000) return 17'h07fff;
        return 17'(v + 18'sh10000);
    endfunction : exp_code

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic check_frame(input logic [18:0] exp, input logic [18:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] frame expected %05h seen %05h", exp, got);
        end
    endtask : check_frame

    task automatic wait_lvl(input string what, input int sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((sel == 0 ? conv_busy : int_osc_on) !== lvl || dcadc_host_inst.timed_out) begin
            @(negedge mclk);
            n++;
            if (n > lim || dcadc_host_inst.timed_out) begin
                err_total++;
                $display("[FAIL] %s expected %b seen timeout", what, lvl);
                complete_run();
            end
        end
    endtask : wait_lvl

    always @(posedge mclk) begin
        if (frame_stb === 1'b1) begin
            if (exp_q.size() > 0) begin
                check_frame(exp_q.pop_front(), frame_q);
            end else begin
                err_total++;
                $display("[FAIL] frame expected none seen %05h", frame_q);
            end
        end
    end

    initial begin
        void'($urandom(76813));
        ch0_code = 18'sh37fff - 18'($urandom_range(999));
        ch1_code = 18'($urandom_range(65535)) - 18'sh08000;
        repeat (12) @(negedge mclk);
        check("reset sdo_oe_n", 1, sdo_oe_n);
        check("reset busy", 1, conv_busy);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        check("osc without clock", 1, int_osc_on);
        f0_run = 1'b1;
        wait_lvl("osc off", 1, 1'b0, 200);
        $display("Test clock detect done");
        exp_q.push_back({2'b00, exp_code(ch0_code)});
        dcadc_host_inst.read_ext(busy_seen);
        wait_lvl("host ext read", 0, 1'b1, 8);
        check("busy on sdo", 1, busy_seen);
        repeat (8) @(negedge mclk);
        check("busy after 19th fall", 1, conv_busy);
        check("sdo after 19th fall", 1, sdo_pin);
        dcadc_host_inst.deselect();
        repeat (6) @(negedge mclk);
        check("sdo released", 1, sdo_oe_n);
        check("sck not driven", 1, sck_oe_n);
        $display("Test external read done");
        wait_lvl("conversion end", 0, 1'b0, 50000);
        repeat (2) @(negedge mclk);
        check("ticks in range", 1, busy_len >= 20506 && busy_len <= 20514);
        exp_q.push_back({2'b01, exp_code(ch1_code)});
        dcadc_host_inst.read_int(spacing);
        wait_lvl("host int read", 0, 1'b1, 8);
        check("sck period", 16, spacing);
        repeat (40) begin
            @(negedge mclk);
            check("sck stays high", 1, sck_out);
        end
        check("busy after 19th rise", 1, conv_busy);
        dcadc_host_inst.deselect();
        $display("Test internal read done");
        f0_run = 1'b0;
        wait_lvl("osc back", 1, 1'b1, DET + 40);
        $display("Test clock loss done");
        check("frames left", 0, exp_q.size());
        complete_run();
    end
endmodule : dcadc_top_tb
